// File: common/psh_pkg.sv
// Constants, register map and mode encodings for the page-select and
// housekeeping register bank.
// Assumes a single 125 MHz clock domain shared by every user.
package psh_pkg;

   // ****************************************************************
   // Register map (byte addresses, low byte of each 16-bit register)
   // ****************************************************************
   localparam logic [6:0]  PSH_A_PAGE     = 7'h00;
   localparam logic [6:0]  PSH_A_TEMP     = 7'h02;
   localparam logic [6:0]  PSH_A_SUPPLY   = 7'h04;
   localparam logic [6:0]  PSH_A_AVG_LO   = 7'h06;
   localparam logic [6:0]  PSH_A_AVG_HI   = 7'h08;

   // ****************************************************************
   // Reset values and pages
   // ****************************************************************
   localparam logic [15:0] PSH_PAGE_RST   = 16'h0000;
   localparam logic [15:0] PSH_RESULT_RST = 16'h8000;
   localparam logic [15:0] PSH_AVG_LO_RST = 16'h0108;
   localparam logic [15:0] PSH_AVG_HI_RST = 16'h0101;
   localparam logic [15:0] PSH_PAGE_CFG   = 16'h0000;
   localparam logic [15:0] PSH_LAST_PAGE  = 16'h0006;

   // ****************************************************************
   // Serial word format and field widths
   // ****************************************************************
   localparam int          PSH_WR_BIT     = 15;
   localparam logic [4:0]  PSH_LAST_BIT   = 5'h0f;
   localparam int          PSH_SUP_W      = 12;
   localparam logic [3:0]  PSH_SUP_PAD    = 4'h0;
   localparam logic [7:0]  PSH_ONE_REC    = 8'h01;

   // ****************************************************************
   // Averaging sequence
   // ****************************************************************
   localparam int          PSH_SAMPLES    = 4096;
   localparam logic [11:0] PSH_LAST_SMP   = 12'(PSH_SAMPLES - 1);
   localparam int          PSH_ACC_W      = 24;
   localparam logic [4:0]  PSH_LAST_STEP  = 5'(PSH_ACC_W - 1);

   typedef enum logic [1:0] {
      PSH_IDLE,
      PSH_MANUAL_SPECTRAL,
      PSH_AUTO_SPECTRAL,
      PSH_TIME_CAPTURE
   } psh_mode_e;

endpackage

// File: design/psh_avg_seq.sv
// Record averaging sequencer: counts samples per record, requests the
// transform, accumulates temperature and supply, divides by the count.
// Assumes the sample, transform and sensor inputs share its clock.
module psh_avg_seq
   import psh_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic [7:0]  count,
   input  wire logic        xform_en,
   input  wire logic        sample_valid,
   input  wire logic        xform_done,
   input  wire logic [15:0] temp_in,
   input  wire logic [11:0] supply_in,
   output logic             xform_start,
   output logic             spec_accum,
   output logic             spec_divide,
   output logic             busy,
   output logic             done,
   output logic [15:0]      temp_avg,
   output logic [11:0]      supply_avg
);

   typedef enum {S_IDLE, S_CAPT, S_XFORM, S_WAIT, S_MEAS, S_DIV,
                 S_DONE} psh_seq_e;

   typedef struct packed {
      psh_seq_e              st;
      logic [7:0]            cnt;
      logic                  xf;
      logic [7:0]            rec;
      logic [11:0]           smp;
      logic [4:0]            step;
      logic [1:0][23:0]      acc;
      logic [1:0][7:0]       rem;
   } psh_seq_s;

   psh_seq_s r, n;

   logic [23:0] acc_add  [2];
   logic [23:0] acc_step [2];
   logic [7:0]  rem_step [2];
   logic [23:0] smp_in   [2];

   // Temperature is biased to offset binary so both channels add unsigned
   assign smp_in[0] = {8'h00, ~temp_in[15], temp_in[14:0]};
   assign smp_in[1] = {8'h00, PSH_SUP_PAD, supply_in};

   // ****************************************************************
   // Per-channel accumulate and restoring divide step
   // ****************************************************************
   genvar g;
   for (g = 0; g < 2; g++) begin : g_ch
      logic [8:0] sh;
      logic       ge;
      assign sh          = {r.rem[g], r.acc[g][23]};
      assign ge          = sh >= {1'b0, r.cnt};
      assign rem_step[g] = ge ? 8'(sh - {1'b0, r.cnt}) : sh[7:0];
      assign acc_step[g] = {r.acc[g][22:0], ge};
      assign acc_add[g]  = r.acc[g] + smp_in[g];
   end

   always_comb begin
      n = r;
      case (r.st)
         S_IDLE: begin
            if (start) begin
               n.st  = S_CAPT;
               n.cnt = count;
               n.xf  = xform_en;
               n.rec = '0;
               n.smp = '0;
               n.acc = '0;
            end
         end
         S_CAPT: begin
            if (sample_valid) begin
               n.smp = r.smp + 12'h001;
               if (r.smp == PSH_LAST_SMP) begin
                  n.st = r.xf ? S_XFORM : S_MEAS;
               end
            end
         end
         S_XFORM: n.st = S_WAIT;
         S_WAIT: begin
            if (xform_done) begin
               n.st = S_MEAS;
            end
         end
         S_MEAS: begin
            n.acc[0] = acc_add[0];
            n.acc[1] = acc_add[1];
            n.rec    = r.rec + 8'h01;
            n.smp    = '0;
            if (r.rec + 8'h01 == r.cnt) begin
               n.st   = S_DIV;
               n.step = '0;
               n.rem  = '0;
            end else begin
               n.st = S_CAPT;
            end
         end
         S_DIV: begin
            n.acc[0] = acc_step[0];
            n.acc[1] = acc_step[1];
            n.rem[0] = rem_step[0];
            n.rem[1] = rem_step[1];
            n.step   = r.step + 5'h01;
            if (r.step == PSH_LAST_STEP) begin
               n.st = S_DONE;
            end
         end
         S_DONE: n.st = S_IDLE;
         default: n.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r    <= '0;
         r.st <= S_IDLE;
      end else begin
         r <= n;
      end
   end

   assign xform_start = r.st == S_XFORM;
   assign spec_accum  = r.st == S_MEAS && r.xf;
   assign spec_divide = r.st == S_DIV && r.step == '0 && r.xf;
   assign busy        = r.st != S_IDLE;
   assign done        = r.st == S_DONE;
   assign temp_avg    = {~r.acc[0][15], r.acc[0][14:0]};
   assign supply_avg  = r.acc[1][11:0];

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_capt_len;
      @(posedge clk) disable iff (srst)
      r.st == S_CAPT && sample_valid && r.smp != PSH_LAST_SMP
         |=> r.st == S_CAPT;
   endproperty
   a_capt_len: assert property (p_capt_len)
      else $error("record left capture before its last sample");

   property p_div_len;
      @(posedge clk) disable iff (srst)
      $rose(r.st == S_DIV) |-> ##23 r.st == S_DIV ##1 r.st == S_DONE;
   endproperty
   a_div_len: assert property (p_div_len)
      else $error("divide did not take its full step count");

   property p_rec_done;
      @(posedge clk) disable iff (srst)
      done |-> r.rec == r.cnt;
   endproperty
   a_rec_done: assert property (p_rec_done)
      else $error("averaging ended before the configured count");

endmodule

// File: design/psh_regs.sv
// Page-select, housekeeping result and spectral averaging registers,
// reached over the serial word port, plus the averaging sequencer.
// Assumes SPI pins asynchronous to clk; engines and flash on clk.
//
// Contract
// - Seven pages; page zero config, others coefficients
// - Page select at bytes 0 and 1, every page
// - Page select 16 bits, resets zero, read write
// - Page two routes writes to bank two coefficients
// - Page write changes target only, no stored values
// - Temperature updated when capture event concludes
// - Temperature code is two's complement sensor code
// - Results read only, read 0x8000 until capture
// - Supply sampled when capture event starts
// - Supply in low twelve bits, upper unused
// - Low averaging register: rates one, zero
// - High averaging register: rates three, two
// - Active rate count selects records averaged
// - Capture, transform, accumulate per record, then divide
// - Supply and temperature averaged alongside spectrum
// - Count one gives a single unaveraged result
module psh_regs
   import psh_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_din,
   output logic             spi_dout,
   input  psh_mode_e        meas_mode,
   input  wire logic [1:0]  rate_sel,
   input  wire logic        capture_start,
   input  wire logic        sample_valid,
   input  wire logic        xform_done,
   input  wire logic [15:0] temp_sample,
   input  wire logic [11:0] supply_sample,
   output logic             xform_start,
   output logic             spec_accum,
   output logic             spec_divide,
   output logic             capture_busy,
   output logic             capture_done,
   input  wire logic [15:0] coef_rdata,
   output logic             coef_wr,
   output logic [15:0]      coef_page,
   output logic [6:0]       coef_addr,
   output logic [7:0]       coef_wdata,
   input  wire logic        flash_load,
   input  wire logic [15:0] flash_page,
   input  wire logic [15:0] flash_avg_lo,
   input  wire logic [15:0] flash_avg_hi,
   output logic [15:0]      page_select,
   output logic [15:0]      avg_rates_low,
   output logic [15:0]      avg_rates_high
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                  sclk_m;
      logic                  sclk_s;
      logic                  sclk_d;
      logic                  cs_m;
      logic                  cs_s;
      logic                  din_m;
      logic                  din_s;
      logic [4:0]            bit_cnt;
      logic [15:0]           sh_in;
      logic [15:0]           sh_out;
      logic                  dout;
      logic [6:0]            rd_addr;
      logic [15:0]           page;
      logic [15:0]           temp;
      logic [15:0]           supply;
      logic [15:0]           avg_lo;
      logic [15:0]           avg_hi;
      psh_mode_e             mode;
      logic                  coef_wr;
      logic [6:0]            coef_addr;
      logic [7:0]            coef_data;
   } psh_regs_s;

   psh_regs_s r, n;

   logic        rise;
   logic        fall;
   logic [15:0] word;
   logic        word_done;
   logic        wr_req;
   logic [6:0]  wr_addr;
   logic [6:0]  wr_reg;
   logic        wr_hi;
   logic [7:0]  wr_data;
   logic        on_cfg_page;
   logic        on_coef_page;
   logic [15:0] rd_word;
   logic [7:0]  raw_count;
   logic [7:0]  eff_count;
   logic [7:0]  seq_count;
   logic        start_ok;
   logic        seq_busy;
   logic        seq_done;
   logic [15:0] temp_avg;
   logic [11:0] supply_avg;

   function automatic logic [15:0] put_byte(input logic [15:0] old,
                                            input logic        hi,
                                            input logic [7:0]  b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   // ****************************************************************
   // Serial word decode
   // ****************************************************************
   assign rise      = r.sclk_s & ~r.sclk_d;
   assign fall      = ~r.sclk_s & r.sclk_d;
   assign word      = {r.sh_in[14:0], r.din_s};
   assign word_done = rise && !r.cs_s && r.bit_cnt == PSH_LAST_BIT;
   assign wr_req    = word_done && word[PSH_WR_BIT];
   assign wr_addr   = word[14:8];
   assign wr_reg    = {wr_addr[6:1], 1'b0};
   assign wr_hi     = wr_addr[0];
   assign wr_data   = word[7:0];

   assign on_cfg_page  = r.page == PSH_PAGE_CFG;
   assign on_coef_page = !on_cfg_page && r.page <= PSH_LAST_PAGE;

   // ****************************************************************
   // Read data for the word addressed in the previous frame
   // ****************************************************************
   always_comb begin
      rd_word = '0;
      if ({r.rd_addr[6:1], 1'b0} == PSH_A_PAGE) begin
         rd_word = r.page;
      end else if (on_coef_page) begin
         rd_word = coef_rdata;
      end else if (on_cfg_page) begin
         case ({r.rd_addr[6:1], 1'b0})
            PSH_A_TEMP:   rd_word = r.temp;
            PSH_A_SUPPLY: rd_word = r.supply;
            PSH_A_AVG_LO: rd_word = r.avg_lo;
            PSH_A_AVG_HI: rd_word = r.avg_hi;
            default:      rd_word = '0;
         endcase
      end
   end

   // ****************************************************************
   // Averaging count for the active rate setting
   // ****************************************************************
   always_comb begin
      case (rate_sel)
         2'h0:    raw_count = r.avg_lo[7:0];
         2'h1:    raw_count = r.avg_lo[15:8];
         2'h2:    raw_count = r.avg_hi[7:0];
         default: raw_count = r.avg_hi[15:8];
      endcase
   end

   assign eff_count = raw_count == '0 ? PSH_ONE_REC : raw_count;
   assign seq_count = meas_mode == PSH_TIME_CAPTURE ? PSH_ONE_REC
                                                    : eff_count;
   assign start_ok  = capture_start && meas_mode != PSH_IDLE && !seq_busy;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      n         = r;
      n.sclk_m  = spi_sclk;
      n.sclk_s  = r.sclk_m;
      n.sclk_d  = r.sclk_s;
      n.cs_m    = spi_cs_n;
      n.cs_s    = r.cs_m;
      n.din_m   = spi_din;
      n.din_s   = r.din_m;
      n.coef_wr = 1'b0;

      // Frame framing and shifting
      if (r.cs_s) begin
         n.bit_cnt = '0;
         n.sh_out  = rd_word;
      end else begin
         if (rise) begin
            n.sh_in   = word;
            n.bit_cnt = r.bit_cnt + 5'h01;
         end
         if (fall) begin
            n.dout   = r.sh_out[15];
            n.sh_out = {r.sh_out[14:0], 1'b0};
         end
      end
      if (word_done) begin
         n.bit_cnt = '0;
         if (!word[PSH_WR_BIT]) begin
            n.rd_addr = wr_addr;
         end
      end

      // Flash restore of the backed-up registers
      if (flash_load) begin
         n.page   = flash_page;
         n.avg_lo = flash_avg_lo;
         n.avg_hi = flash_avg_hi;
      end

      // Register writes; page writes touch nothing else
      if (wr_req) begin
         if (wr_reg == PSH_A_PAGE) begin
            n.page = put_byte(r.page, wr_hi, wr_data);
         end else if (on_coef_page) begin
            n.coef_wr   = 1'b1;
            n.coef_addr = wr_addr;
            n.coef_data = wr_data;
         end else if (on_cfg_page) begin
            case (wr_reg)
               PSH_A_AVG_LO: n.avg_lo = put_byte(r.avg_lo, wr_hi, wr_data);
               PSH_A_AVG_HI: n.avg_hi = put_byte(r.avg_hi, wr_hi, wr_data);
               default: n.avg_lo = r.avg_lo;
            endcase
         end
      end

      // Measurement results
      if (start_ok) begin
         n.mode   = meas_mode;
         n.supply = {PSH_SUP_PAD, supply_sample};
      end
      if (seq_done) begin
         n.temp = temp_avg;
         if (r.mode != PSH_TIME_CAPTURE) begin
            n.supply = {PSH_SUP_PAD, supply_avg};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r         <= '0;
         r.sclk_m  <= 1'b1;
         r.sclk_s  <= 1'b1;
         r.sclk_d  <= 1'b1;
         r.cs_m    <= 1'b1;
         r.cs_s    <= 1'b1;
         r.mode    <= PSH_IDLE;
         r.page    <= PSH_PAGE_RST;
         r.temp    <= PSH_RESULT_RST;
         r.supply  <= PSH_RESULT_RST;
         r.avg_lo  <= PSH_AVG_LO_RST;
         r.avg_hi  <= PSH_AVG_HI_RST;
      end else begin
         r <= n;
      end
   end

   // ****************************************************************
   // Averaging sequencer
   // ****************************************************************
   psh_avg_seq u_seq (
      .clk          (clk),
      .srst         (srst),
      .start        (start_ok),
      .count        (seq_count),
      .xform_en     (meas_mode != PSH_TIME_CAPTURE),
      .sample_valid (sample_valid),
      .xform_done   (xform_done),
      .temp_in      (temp_sample),
      .supply_in    (supply_sample),
      .xform_start  (xform_start),
      .spec_accum   (spec_accum),
      .spec_divide  (spec_divide),
      .busy         (seq_busy),
      .done         (seq_done),
      .temp_avg     (temp_avg),
      .supply_avg   (supply_avg)
   );

   assign spi_dout       = r.dout;
   assign capture_busy   = seq_busy;
   assign capture_done   = seq_done;
   assign coef_wr        = r.coef_wr;
   assign coef_page      = r.page;
   assign coef_addr      = r.coef_addr;
   assign coef_wdata     = r.coef_data;
   assign page_select    = r.page;
   assign avg_rates_low  = r.avg_lo;
   assign avg_rates_high = r.avg_hi;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_rst_val;
      @(posedge clk)
      $past(srst) && !srst && !flash_load |-> r.temp == PSH_RESULT_RST
         && r.supply == PSH_RESULT_RST && r.avg_lo == PSH_AVG_LO_RST
         && r.avg_hi == PSH_AVG_HI_RST && r.page == PSH_PAGE_RST;
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("register reset values wrong");

   property p_page_wr;
      @(posedge clk) disable iff (srst)
      wr_req && wr_reg == PSH_A_PAGE && !wr_hi
         |=> r.page[7:0] == $past(wr_data);
   endproperty
   a_page_wr: assert property (p_page_wr)
      else $error("page select write not taken");

   property p_coef;
      @(posedge clk) disable iff (srst)
      wr_req && wr_reg != PSH_A_PAGE && r.page == 16'h0002
         |=> coef_wr && coef_page == 16'h0002 ##1 !coef_wr;
   endproperty
   a_coef: assert property (p_coef)
      else $error("coefficient page write not routed");

   property p_keep;
      @(posedge clk) disable iff (srst)
      wr_req && wr_reg == PSH_A_PAGE && !flash_load
         |=> $stable(r.avg_lo) && $stable(r.avg_hi);
   endproperty
   a_keep: assert property (p_keep)
      else $error("page write altered a stored register");

   property p_ro;
      @(posedge clk) disable iff (srst)
      wr_req && !seq_done && !start_ok
         && (wr_reg == PSH_A_TEMP || wr_reg == PSH_A_SUPPLY)
         |=> $stable(r.temp) && $stable(r.supply);
   endproperty
   a_ro: assert property (p_ro)
      else $error("result register changed by a write");

   property p_sup_start;
      @(posedge clk) disable iff (srst)
      start_ok |=> r.supply == {PSH_SUP_PAD, $past(supply_sample)};
   endproperty
   a_sup_start: assert property (p_sup_start)
      else $error("supply not sampled at capture start");

   property p_zero;
      @(posedge clk) disable iff (srst)
      start_ok |-> seq_count != 8'h00
         && (raw_count != 8'h00 || seq_count == PSH_ONE_REC);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero averaging count reached the sequencer");

   property p_temp_done;
      @(posedge clk) disable iff (srst)
      seq_done |=> r.temp == $past(temp_avg) ##1 $stable(r.temp);
   endproperty
   a_temp_done: assert property (p_temp_done)
      else $error("temperature not latched at capture end");

endmodule

// File: tb/psh_host_model.sv
// Serial host model: one 16-bit word per frame, MSB first.
// Assumes sclk idle high and the device shifting out on sclk falls.
module psh_host_model (
   input  wire logic dout,
   input  wire logic clk,
   output logic      sclk,
   output logic      cs_n,
   output logic      din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   // Write flag, byte address and one byte per word
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      repeat (6) @(posedge clk);
      cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (6) @(posedge clk);
         sclk <= 1'b0;
         din  <= w[i];
         repeat (6) @(posedge clk);
         sclk <= 1'b1;
         r[i] = dout;
      end
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
      din  <= ~din;
   endtask
endmodule

// File: tb/psh_regs_tb_top.sv
// Testbench for the page-select and housekeeping register bank.
// Assumes the host model for frames and a bench-driven capture engine.
module psh_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import psh_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        spi_sclk, spi_cs_n, spi_din, spi_dout;
   psh_mode_e   meas_mode = PSH_IDLE;
   logic [1:0]  rate_sel = 2'h0;
   logic        capture_start = 1'b0;
   logic        sample_valid = 1'b0;
   logic        xform_done = 1'b0;
   logic        flash_load = 1'b0;
   logic [15:0] temp_sample = 16'h03bc;
   logic [11:0] supply_sample = 12'h401;
   logic        xform_start, spec_accum, spec_divide;
   logic        capture_busy, capture_done, coef_wr;
   logic [15:0] coef_page, page_select, avg_rates_low, avg_rates_high;
   logic [6:0]  coef_addr, cw_a;
   logic [7:0]  coef_wdata, cw_d;
   logic [15:0] cw_pg, n_xf, n_acc, n_div;
   int          err_count = 0;
   int          samples_checked = 0;
   logic [6:0]  ra [5] = '{PSH_A_PAGE, PSH_A_TEMP, PSH_A_SUPPLY,
                           PSH_A_AVG_LO, PSH_A_AVG_HI};
   logic [15:0] rv [5] = '{16'h0000, 16'h8000, 16'h8000,
                           16'h0108, 16'h0101};

   always #4 clk = ~clk;

   psh_regs u_psh_regs (
      .clk(clk), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_din(spi_din), .spi_dout(spi_dout), .meas_mode(meas_mode),
      .rate_sel(rate_sel), .capture_start(capture_start),
      .sample_valid(sample_valid), .xform_done(xform_done),
      .temp_sample(temp_sample), .supply_sample(supply_sample),
      .xform_start(xform_start), .spec_accum(spec_accum),
      .spec_divide(spec_divide), .capture_busy(capture_busy),
      .capture_done(capture_done), .coef_rdata(16'hc3a5),
      .coef_wr(coef_wr), .coef_page(coef_page), .coef_addr(coef_addr),
      .coef_wdata(coef_wdata), .flash_load(flash_load),
      .flash_page(16'h0003), .flash_avg_lo(16'h0203),
      .flash_avg_hi(16'h0405), .page_select(page_select),
      .avg_rates_low(avg_rates_low), .avg_rates_high(avg_rates_high));
   psh_host_model u_host (.clk(clk), .dout(spi_dout), .sclk(spi_sclk),
      .cs_n(spi_cs_n), .din(spi_din));

   // ****************************************************************
   // Capture engine stand-in and pulse counters
   // ****************************************************************
   always @(posedge clk) begin
      sample_valid <= capture_busy & ~sample_valid;
      xform_done   <= xform_start;
   end
   always @(negedge clk) begin
      n_xf  += 16'(xform_start === 1'b1);
      n_acc += 16'(spec_accum === 1'b1);
      n_div += 16'(spec_divide === 1'b1);
      if (coef_wr === 1'b1) begin
         cw_pg = coef_page;
         cw_a  = coef_addr;
         cw_d  = coef_wdata;
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      u_host.xfer({1'b1, a, d}, r);
   endtask
   // Answer to a read word arrives in the following frame
   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] r;
      u_host.xfer({1'b0, a, 8'h00}, r);
      u_host.xfer({1'b0, a, 8'h00}, r);
      chk($sformatf("reg %h", a), r, exp);
   endtask
   task automatic cap(input psh_mode_e m, input logic [1:0] rs,
                      input logic [15:0] n);
      meas_mode <= m;
      rate_sel  <= rs;
      @(posedge clk);
      capture_start <= 1'b1;
      n_xf  = 16'h0000;
      n_acc = 16'h0000;
      n_div = 16'h0000;
      @(posedge clk);
      capture_start <= 1'b0;
      for (int i = 0; i < 40000 && capture_done !== 1'b1; i++)
         @(negedge clk);
      chk("done", {15'h0000, capture_done}, 16'h0001);
      chk("busy", {15'h0000, capture_busy}, 16'h0001);
      if (m != PSH_TIME_CAPTURE) begin
         chk("xform", n_xf, n);
         chk("accum", n_acc, n);
         chk("divide", n_div, 16'h0001);
      end else begin
         chk("xform", n_xf, 16'h0000);
         chk("accum", n_acc, 16'h0000);
      end
      rdchk(PSH_A_TEMP, 16'h03bc);
      rdchk(PSH_A_SUPPLY, 16'h0401);
   endtask
   task automatic wrap_up;
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #720000;
      err_count++;
      wrap_up;
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      foreach (ra[i]) rdchk(ra[i], rv[i]);
      wr(7'h02, 8'hff);
      wr(7'h03, 8'h12);
      rdchk(PSH_A_TEMP, 16'h8000);
      wr(7'h06, 8'h01);
      wr(7'h07, 8'h01);
      rdchk(PSH_A_AVG_LO, 16'h0101);
      wr(7'h08, 8'h02);
      wr(7'h09, 8'h04);
      rdchk(PSH_A_AVG_HI, 16'h0402);
      wr(7'h00, 8'h02);
      wr(7'h0a, 8'h5a);
      chk("page", cw_pg, 16'h0002);
      chk("coef", {1'b0, cw_a, cw_d}, 16'h0a5a);
      rdchk(PSH_A_PAGE, 16'h0002);
      rdchk(PSH_A_AVG_LO, 16'hc3a5);
      wr(7'h00, 8'h07);
      wr(7'h01, 8'h01);
      rdchk(PSH_A_PAGE, 16'h0107);
      rdchk(PSH_A_AVG_LO, 16'h0000);
      wr(7'h0a, 8'h11);
      chk("coef", {1'b0, cw_a, cw_d}, 16'h0a5a);
      wr(7'h00, 8'h00);
      wr(7'h01, 8'h00);
      rdchk(PSH_A_AVG_LO, 16'h0101);
      cap(PSH_TIME_CAPTURE, 2'h0, 16'h0001);
      cap(PSH_MANUAL_SPECTRAL, 2'h2, 16'h0002);
      cap(PSH_AUTO_SPECTRAL, 2'h1, 16'h0001);
      wr(7'h08, 8'h00);
      chk("avg_out", avg_rates_high, 16'h0400);
      cap(PSH_MANUAL_SPECTRAL, 2'h2, 16'h0001);
      flash_load <= 1'b1;
      @(posedge clk);
      flash_load <= 1'b0;
      @(negedge clk);
      chk("page_out", page_select, 16'h0003);
      chk("avg_lo_out", avg_rates_low, 16'h0203);
      chk("avg_hi_out", avg_rates_high, 16'h0405);
      wrap_up;
   end
endmodule
